/* src/bscan_port.v */
`include "bscan_consts.vh"

//Function
//RL1: 188-cell boundary chain sequenced by TAP
//RL2: bit 0 nearest serial output, leaves first
//RL3: cells are output, input or control types
//RL4: output cells capture internal output latch
//RL5: bidirectional pin has input and output cells
//RL6: five control cells, one per pin; the code shares each cell across pins by pin index mod 5
//RL7: control one enables governed pin drivers
//RL8: control cells capture their present value
//RL9: test-logic-reset clears all control cells
//RL10: tester never drives into driven nets
//RL11: power-on reset clears system and test logic
//RL12: TAP held in reset while power-on active
//RL13: outside reset, stop cannot reach lowest power
//RL14: test clock stays live in stop state
//RL15: system asserts reset within eight bus clocks
//RL16: no reset, start reset on tenth clock
//RL17: unused scan systems force TAP reset
//RL18: external test selects chain, resets system
//RL19: sample captures pins without disturbing system
//RL20: five TMS-high edges reach test-logic-reset
//RL21: serial output driven only in shift states
//RL22: shift toward bit 0, update loads hold
module bscan_port #(
  parameter NBIDIR = `BSC_NBIDIR,
  parameter NIN    = `BSC_NIN,
  parameter NOUT   = `BSC_NOUT
) (
  // clock and reset
  input  wire              mclk_i,
  input  wire              rst_n_i,
  // test access pins
  input  wire              tck_i,
  input  wire              tms_i,
  input  wire              tdi_i,
  output reg               tdo_o,
  output reg               tdo_oe_o,
  // power-on, bus clock, reset pin, stop mode
  input  wire              por_i,
  input  wire              bclk_i,
  input  wire              system_reset_input_n_i,
  input  wire              low_power_stop_state_i,
  output reg               sys_reset_o,
  output reg               reset_start_o,
  output reg               lowest_power_ok_o,
  // system side of the pins
  input  wire [NOUT-1:0]   sys_out_i,
  input  wire [NOUT-1:0]   sys_out_oe_i,
  input  wire [NBIDIR-1:0] sys_io_out_i,
  input  wire [NBIDIR-1:0] sys_io_oe_i,
  output reg  [NIN-1:0]    core_in_o,
  output reg  [NBIDIR-1:0] core_io_in_o,
  // device pins
  input  wire [NIN-1:0]    pin_in_i,
  input  wire [NBIDIR-1:0] pin_io_i,
  output reg  [NBIDIR-1:0] pin_io_o,
  output reg  [NBIDIR-1:0] pin_io_oe_o,
  output reg  [NOUT-1:0]   pin_out_o,
  output reg  [NOUT-1:0]   pin_out_oe_o
);

  localparam TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3;
  localparam SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7;
  localparam UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB;
  localparam EX1_IR = 4'hC, PA_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF;
  localparam LEN = `BSC_CHAIN_LEN;

  // which of the five control cells governs a pin
  function integer ctl_of;
    input integer pin;
    begin
      ctl_of = pin % `BSC_NCTL; // RL6
    end
  endfunction

  // two-stage synchronisers; stage 1 feeds only stage 2
  reg [2:0]        tck_s;
  reg [1:0]        tms_s, tdi_s, por_s, bclk_s, sysrst_s;
  reg              bclk_d;
  reg [NIN-1:0]    in_s1;
  reg [NBIDIR-1:0] io_s1;

  reg [3:0]        tap, next_tap;
  reg [2:0]        ir, ir_shift;
  reg              bypass;
  reg              armed;
  reg [3:0]        bclk_cnt;

  wire             tck_rise = tck_s[1] & ~tck_s[2];
  wire             tck_fall = ~tck_s[1] & tck_s[2];
  wire             tms      = tms_s[1];
  wire             tdi      = tdi_s[1];
  wire             por      = por_s[1];
  wire             bclk_rise = bclk_s[1] & ~bclk_d;
  wire             sysrst_on = ~sysrst_s[1];
  wire             sel_chain = (ir == `IR_EXTEST) || (ir == `IR_SAMPLE); // RL18 RL19
  wire             pins_test = (ir == `IR_EXTEST) || (ir == `IR_CLAMP);
  wire             highz     = (ir == `IR_HIGHZ);
  wire             in_tlr    = por || (tap == TLR);
  wire             leave_ext = (ir == `IR_EXTEST) &&
                               (por || (tck_rise && ((tap == TLR) ||
                               ((tap == UPD_IR) && (ir_shift != `IR_EXTEST)))));
  wire             chain_so;
  wire [LEN-1:0]   hold;
  reg  [LEN-1:0]   cap;
  integer          k;
  // separate loop index for the clocked drivers, so k has one owner
  integer          j;

  // capture sources: output latches, pin levels; control slots refilled inside
  always @* begin
    cap = {LEN{1'b0}};
    for (k = 0; k < NBIDIR; k = k + 1) begin
      cap[`BSC_BIDIR_LSB + 2*k]     = core_io_in_o[k]; // RL5
      cap[`BSC_BIDIR_LSB + 2*k + 1] = sys_io_out_i[k]; // RL5 RL4
    end
    for (k = 0; k < NIN; k = k + 1) begin
      cap[`BSC_IN_LSB + k] = core_in_o[k]; // RL3
    end
    for (k = 0; k < NOUT; k = k + 1) begin
      cap[`BSC_OUT_LSB + k] = sys_out_i[k]; // RL4
    end
  end

  bscan_cells #(
    .LEN  (LEN),
    .NCTL (`BSC_NCTL)
  ) u_cells (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .capture_i   (tck_rise && (tap == CAP_DR) && sel_chain),
    .shift_i     (tck_rise && (tap == SH_DR) && sel_chain),
    .update_i    (tck_rise && (tap == UPD_DR) && sel_chain),
    .clear_ctl_i (in_tlr),
    .tdi_i       (tdi),
    .cap_data_i  (cap),
    .so_o        (chain_so),
    .hold_o      (hold)
  ); // RL1

  // TAP sequencing; TMS high five edges lands in reset from anywhere
  always @* begin
    case (tap)
      TLR:     next_tap = tms ? TLR : RTI; // RL20
      RTI:     next_tap = tms ? SEL_DR : RTI;
      SEL_DR:  next_tap = tms ? SEL_IR : CAP_DR;
      CAP_DR:  next_tap = tms ? EX1_DR : SH_DR;
      SH_DR:   next_tap = tms ? EX1_DR : SH_DR;
      EX1_DR:  next_tap = tms ? UPD_DR : PA_DR;
      PA_DR:   next_tap = tms ? EX2_DR : PA_DR;
      EX2_DR:  next_tap = tms ? UPD_DR : SH_DR;
      UPD_DR:  next_tap = tms ? SEL_DR : RTI;
      SEL_IR:  next_tap = tms ? TLR : CAP_IR; // RL20
      CAP_IR:  next_tap = tms ? EX1_IR : SH_IR;
      SH_IR:   next_tap = tms ? EX1_IR : SH_IR;
      EX1_IR:  next_tap = tms ? UPD_IR : PA_IR;
      PA_IR:   next_tap = tms ? EX2_IR : PA_IR;
      EX2_IR:  next_tap = tms ? UPD_IR : SH_IR;
      UPD_IR:  next_tap = tms ? SEL_DR : RTI;
      default: next_tap = TLR;
    endcase
  end

  // test clock is sampled even in stop; holding it static saves power
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tck_s  <= 3'h0; // RL14
      tms_s  <= 2'h3;
      tdi_s  <= 2'h3;
      por_s  <= 2'h3;
      bclk_s <= 2'h0;
      bclk_d <= 1'b0;
      sysrst_s <= 2'h3;
      in_s1  <= {NIN{1'b0}};
      io_s1  <= {NBIDIR{1'b0}};
      core_in_o    <= {NIN{1'b0}};
      core_io_in_o <= {NBIDIR{1'b0}};
    end else begin
      tck_s  <= {tck_s[1:0], tck_i};
      tms_s  <= {tms_s[0], tms_i};
      tdi_s  <= {tdi_s[0], tdi_i};
      por_s  <= {por_s[0], por_i};
      bclk_s <= {bclk_s[0], bclk_i};
      bclk_d <= bclk_s[1];
      sysrst_s <= {sysrst_s[0], system_reset_input_n_i};
      in_s1  <= pin_in_i;
      io_s1  <= pin_io_i;
      core_in_o    <= in_s1;
      core_io_in_o <= io_s1;
    end
  end

  // TAP, instruction and bypass stages
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap      <= TLR; // RL11
      ir       <= `IR_RESET_VAL;
      ir_shift <= `IR_RESET_VAL;
      bypass   <= 1'b0;
    end else if (por) begin
      tap      <= TLR; // RL12 RL11
      ir       <= `IR_RESET_VAL;
      ir_shift <= `IR_RESET_VAL;
    end else if (tck_rise) begin
      tap <= next_tap;
      case (tap)
        TLR:     ir <= `IR_RESET_VAL;
        CAP_IR:  ir_shift <= `IR_CAPTURE_VAL;
        SH_IR:   ir_shift <= {tdi, ir_shift[2:1]};
        UPD_IR:  ir <= ir_shift;
        CAP_DR:  bypass <= 1'b0;
        SH_DR:   bypass <= tdi;
        default: bypass <= bypass;
      endcase
    end
  end

  // serial output moves on the falling test clock edge
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (por) begin
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_o <= (tap == SH_DR) || (tap == SH_IR); // RL21
      if (tap == SH_IR)
        tdo_o <= ir_shift[0];
      else
        tdo_o <= sel_chain ? chain_so : bypass; // RL2
    end
  end

  // post external-test reset window; reset pin asserted before the tenth bus clock edge cancels the self-start
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed         <= 1'b0;
      bclk_cnt      <= 4'h0;
      reset_start_o <= 1'b0;
    end else begin
      reset_start_o <= 1'b0;
      if (leave_ext) begin
        armed    <= 1'b1;
        bclk_cnt <= 4'h0;
      end else if (armed && sysrst_on) begin
        armed <= 1'b0; // RL15
      end else if (armed && bclk_rise) begin
        bclk_cnt <= bclk_cnt + 4'h1;
        if (bclk_cnt + 4'h1 == `RST_START_BCLK) begin
          reset_start_o <= 1'b1; // RL16
          armed         <= 1'b0;
        end
      end
    end
  end

  // pin drivers and system status, all registered
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_reset_o       <= 1'b1;
      lowest_power_ok_o <= 1'b1;
      pin_io_o          <= {NBIDIR{1'b0}};
      pin_io_oe_o       <= {NBIDIR{1'b0}};
      pin_out_o         <= {NOUT{1'b0}};
      pin_out_oe_o      <= {NOUT{1'b0}};
    end else begin
      sys_reset_o       <= por || (ir == `IR_EXTEST) || highz; // RL18 RL11
      lowest_power_ok_o <= ~low_power_stop_state_i | in_tlr; // RL13
      // driver contention on the board is the tester's concern
      for (j = 0; j < NBIDIR; j = j + 1) begin
        pin_io_o[j]    <= pins_test ? hold[`BSC_BIDIR_LSB + 2*j + 1] : sys_io_out_i[j];
        pin_io_oe_o[j] <= highz ? 1'b0 :
                          pins_test ? hold[ctl_of(j)] : sys_io_oe_i[j]; // RL7 RL10
      end
      for (j = 0; j < NOUT; j = j + 1) begin
        pin_out_o[j]    <= pins_test ? hold[`BSC_OUT_LSB + j] : sys_out_i[j];
        pin_out_oe_o[j] <= highz ? 1'b0 :
                           pins_test ? hold[ctl_of(j)] : sys_out_oe_i[j]; // RL7
      end
    end
  end

endmodule

/* src/bscan_consts.vh */
`ifndef BSCAN_CONSTS_VH
`define BSCAN_CONSTS_VH

// chain geometry
`define BSC_CHAIN_LEN   188
`define BSC_NCTL        5
`define BSC_NBIDIR      40
`define BSC_NIN         50
`define BSC_NOUT        53
`define BSC_CTL_LSB     0
`define BSC_BIDIR_LSB   5
`define BSC_IN_LSB      85
`define BSC_OUT_LSB     135

// instruction register
`define IR_WIDTH        3
`define IR_EXTEST       3'h0
`define IR_HIGHZ        3'h1
`define IR_SAMPLE       3'h2
`define IR_CLAMP        3'h4
`define IR_PRIVATE      3'h6
`define IR_BYPASS       3'h7
`define IR_CAPTURE_VAL  3'h1
`define IR_RESET_VAL    3'h7

// post external-test reset window, in bus clock edges
`define RST_WINDOW_BCLK 4'h8
`define RST_START_BCLK  4'hA

`endif

/* src/bscan_cells.v */
`include "bscan_consts.vh"

// boundary chain: capture/shift stage plus parallel hold stage
module bscan_cells #(
  parameter LEN  = `BSC_CHAIN_LEN,
  parameter NCTL = `BSC_NCTL
) (
  // clock and reset
  input  wire           mclk_i,
  input  wire           rst_n_i,
  // sequencing strobes, one mclk each; clear_ctl_i is a level held through reset
  input  wire           capture_i,
  input  wire           shift_i,
  input  wire           update_i,
  input  wire           clear_ctl_i,
  input  wire           tdi_i,
  input  wire [LEN-1:0] cap_data_i,
  // results
  output wire           so_o,
  output reg  [LEN-1:0] hold_o
);

  reg [LEN-1:0] stage;

  assign so_o = stage[0];

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage  <= {LEN{1'b0}};
      hold_o <= {LEN{1'b0}};
    end else begin
      if (clear_ctl_i) begin
        stage[NCTL-1:0]  <= {NCTL{1'b0}}; // RL9
        hold_o[NCTL-1:0] <= {NCTL{1'b0}}; // RL9
      end else if (capture_i) begin
        // control cells observe their own held value
        stage <= {cap_data_i[LEN-1:NCTL], hold_o[NCTL-1:0]}; // RL8 RL4
      end else if (shift_i) begin
        stage <= {tdi_i, stage[LEN-1:1]}; // RL22 RL2
      end else if (update_i) begin
        hold_o <= stage; // RL22
      end
    end
  end

endmodule

/* verification/bscan_port_properties.sv */
module bscan_port_properties (
  // clock and reset
  input logic mclk_i,
  input logic rst_n_i,
  // watched inputs
  input logic tck_i,
  input logic por_i,
  input logic bclk_i,
  input logic system_reset_input_n_i,
  input logic low_power_stop_state_i,
  // watched outputs
  input logic tdo_o,
  input logic tdo_oe_o,
  input logic sys_reset_o,
  input logic reset_start_o,
  input logic lowest_power_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       tck_d;
  logic       bclk_d;
  logic [3:0] tck_age;
  logic [3:0] bclk_age;

  // ages saturate so a long idle link never wraps back into range
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tck_d    <= 1'b0;
      bclk_d   <= 1'b0;
      tck_age  <= 4'hF;
      bclk_age <= 4'hF;
    end else begin
      tck_d    <= tck_i;
      bclk_d   <= bclk_i;
      tck_age  <= (tck_d & ~tck_i) ? 4'h0 : tck_age + {3'h0, tck_age != 4'hF};
      bclk_age <= (~bclk_d & bclk_i) ? 4'h0 : bclk_age + {3'h0, bclk_age != 4'hF};
    end
  end

  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence por_held;
    por_i [*8];
  endsequence
  sequence start_quiet;
    !reset_start_o [*8];
  endsequence

  chk_por_no_tdo: assert property (por_held |-> !tdo_oe_o)
    else $error("tdo driven under power-on reset");
  chk_por_sysrst: assert property (por_held |-> sys_reset_o)
    else $error("system not reset under power-on reset");
  chk_por_power: assert property (por_held ##1 low_power_stop_state_i [*2] |-> lowest_power_ok_o)
    else $error("tap left reset under power-on reset");
  chk_run_power: assert property (!low_power_stop_state_i [*2] |-> lowest_power_ok_o)
    else $error("power flag low outside stop");
  chk_start_single: assert property (reset_start_o |=> !reset_start_o)
    else $error("reset start longer than one cycle");
  chk_start_bclk: assert property (reset_start_o |-> bclk_age inside {[2:7]})
    else $error("reset start not tied to bus clock edge");
  chk_start_cancel: assert property ($fell(system_reset_input_n_i) |-> ##4 start_quiet)
    else $error("reset start after reset pin asserted");
  chk_tdo_fall: assert property ($changed({tdo_o, tdo_oe_o}) |-> tck_age inside {[2:6]})
    else $error("tdo changed away from tck fall");
endmodule

/* verification/tap_tester.sv */
module tap_tester (
  // clock
  input  logic mclk_i,
  // test access pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input  logic tdo_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // tck parked low between frames to save stop power
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // 40 ns low then 40 ns high; tdo read mid-high, before the shift lands
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge mclk_i);
    tms_o = tms;
    tdi_o = tdi;
    repeat (3) @(negedge mclk_i);
    tck_o = 1'b1;
    repeat (2) @(negedge mclk_i);
    tdo = tdo_i;
    repeat (2) @(negedge mclk_i);
    tck_o = 1'b0;
  endtask
  task automatic moves(input logic [4:0] tms, input int n);
    logic d;
    for (int i = 0; i < n; i++) step(tms[i], 1'b1, d);
  endtask
  task automatic tlr();
    moves(5'h1F, 5);
  endtask
  task automatic ir(input logic [2:0] code);
    logic d;
    moves(5'h06, 5);
    for (int i = 0; i < 3; i++) step(i == 2, code[i], d);
    moves(5'h01, 2);
  endtask
  task automatic dr(input logic [187:0] din, output logic [187:0] dout);
    moves(5'h02, 4);
    for (int i = 0; i < 188; i++) step(i == 187, din[i], dout[i]);
    moves(5'h01, 2);
  endtask
endmodule

/* verification/tb.sv */
`include "bscan_consts.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, rst_n_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, por_i, bclk_i;
  logic        system_reset_input_n_i, low_power_stop_state_i;
  logic        sys_reset_o, reset_start_o, lowest_power_ok_o;
  logic [52:0] sys_out_i, sys_out_oe_i, pin_out_o, pin_out_oe_o;
  logic [49:0] pin_in_i, core_in_o;
  logic [39:0] sys_io_out_i, sys_io_oe_i, core_io_in_o, io_drv, pin_io_i, pin_io_o, pin_io_oe_o;
  int          miscompares, checks_done, pulses, cycles;

  // board drives a bidir net only while the device has released it
  assign pin_io_i = (pin_io_oe_o & pin_io_o) | (~pin_io_oe_o & io_drv);

  bscan_port dut (
    .mclk_i, .rst_n_i, .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o, .por_i, .bclk_i,
    .system_reset_input_n_i, .low_power_stop_state_i, .sys_reset_o, .reset_start_o,
    .lowest_power_ok_o, .sys_out_i, .sys_out_oe_i, .sys_io_out_i, .sys_io_oe_i, .core_in_o,
    .core_io_in_o, .pin_in_i, .pin_io_i, .pin_io_o, .pin_io_oe_o, .pin_out_o, .pin_out_oe_o
  );
  // undriven tdo reads inverted so a read outside the shift window shows up
  tap_tester tst (.mclk_i, .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_oe_o ? tdo_o : ~tdo_o));

  always #5 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cycles++;
    if (reset_start_o === 1'b1) pulses++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [187:0] seen, input logic [187:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [187:0] chain(input logic [4:0] ctl);
    logic [187:0] c;
    c[4:0] = ctl;
    for (int k = 0; k < 40; k++) c[5+2*k] = pin_io_i[k];
    for (int k = 0; k < 40; k++) c[6+2*k] = sys_io_out_i[k];
    c[134:85] = pin_in_i;
    c[187:135] = sys_out_i;
    return c;
  endfunction

  task automatic bclk_edges(input int n);
    repeat (n) begin
      @(negedge mclk_i);
      bclk_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      bclk_i = 1'b0;
      repeat (3) @(negedge mclk_i);
    end
  endtask

  task automatic t_sample();
    logic [187:0] got;
    tst.ir(`IR_SAMPLE);
    tst.dr('0, got);
    check("capture", got, chain(5'h00));
    check("no reset", sys_reset_o, 1'b0);
    check("sys drive", pin_out_o, sys_out_i);
    check("core in", core_in_o, pin_in_i);
    check("core io in", core_io_in_o, pin_io_i);
    check("tdo released", tdo_oe_o, 1'b0);
    $display("sample test done");
  endtask

  task automatic t_extest();
    logic [187:0] p, got;
    logic [52:0]  eo, eoe, eio;
    p = {47{4'hA}};
    p[4:0] = 5'h15;
    for (int k = 0; k < 53; k++) begin
      eo[k] = p[135+k];
      eoe[k] = p[k%5];
      eio[k] = p[6+2*k];
    end
    tst.ir(`IR_SAMPLE);
    tst.dr(p, got);
    tst.ir(`IR_EXTEST);
    check("out", pin_out_o, eo);
    check("out oe", pin_out_oe_o, eoe);
    check("io", pin_io_o, eio[39:0]);
    check("io oe", pin_io_oe_o, eoe[39:0]);
    check("ext reset", sys_reset_o, 1'b1);
    tst.dr(p, got);
    check("ctl capture", got[4:0], p[4:0]);
    check("latch capture", got[187:135], sys_out_i);
    $display("extest test done");
  endtask

  task automatic t_window();
    int base;
    base = pulses;
    tst.ir(`IR_BYPASS);
    bclk_edges(9);
    check("start early", pulses - base, 0);
    bclk_edges(1);
    check("start tenth", pulses - base, 1);
    tst.ir(`IR_EXTEST);
    tst.ir(`IR_BYPASS);
    bclk_edges(3);
    system_reset_input_n_i = 1'b0;
    bclk_edges(1);
    system_reset_input_n_i = 1'b1;
    bclk_edges(9);
    check("start cancel", pulses - base, 1);
    $display("window test done");
  endtask

  task automatic t_power();
    logic [187:0] got;
    low_power_stop_state_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    check("stop run", lowest_power_ok_o, 1'b0);
    tst.tlr();
    repeat (4) @(negedge mclk_i);
    check("stop reset", lowest_power_ok_o, 1'b1);
    por_i = 1'b1;
    tst.ir(`IR_EXTEST);
    check("por tap", lowest_power_ok_o, 1'b1);
    check("por sys", sys_reset_o, 1'b1);
    por_i = 1'b0;
    low_power_stop_state_i = 1'b0;
    tst.ir(`IR_SAMPLE);
    tst.dr('0, got);
    check("ctl clear", got, chain(5'h00));
    $display("power test done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    por_i = 1'b0;
    bclk_i = 1'b0;
    system_reset_input_n_i = 1'b1;
    low_power_stop_state_i = 1'b0;
    sys_out_i = 53'h0F_0F0F_3C3C_A5A5;
    sys_out_oe_i = 53'h1F_FFFF_FFFF_FFFF;
    sys_io_out_i = 40'hC3_A5A5_0F0F;
    sys_io_oe_i = 40'h00_0000_0000;
    pin_in_i = 50'h2_3C3C_5A5A_9696;
    io_drv = 40'h96_3C3C_A5A5;
    repeat (20) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    t_sample();
    t_extest();
    t_window();
    t_power();
    close_out();
  end
endmodule

bind bscan_port bscan_port_properties chk (
  .mclk_i, .rst_n_i, .tck_i, .por_i, .bclk_i, .system_reset_input_n_i, .low_power_stop_state_i,
  .tdo_o, .tdo_oe_o, .sys_reset_o, .reset_start_o, .lowest_power_ok_o
);
